// ==== design/aoc_pkg.sv ====
// Purpose: Shared constants and types of the alarm output and clamp control block.
// Assumes: Registers sit on 32-bit Avalon-MM words, byte address is four times the index.
// Notes: Register data is 16 bits wide in the low half of each word.
package aoc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is the index shifted left by two.
  localparam logic [7:0] IDX_CLAMP = 8'h1a;
  localparam logic [7:0] IDX_CONFIG = 8'h1b;
  localparam logic [7:0] IDX_FLAGS = 8'h1e;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] IDX_AMP_RESTORE = 8'h22;
  localparam logic [7:0] IDX_CLAMP_RELEASE = 8'h23;
  localparam int unsigned WORD_SHIFT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and reset values.
  localparam int unsigned REG_W = 16;
  localparam int unsigned NUM_CLAMP = 6;
  localparam int unsigned NUM_ENABLE = 13;
  localparam int unsigned NUM_IRQ = 3;
  localparam logic [15:0] CLAMP_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;

  // Clamp register fields.
  localparam int unsigned CLP_AMP_OFF = 6;
  localparam int unsigned CLP_RSV_LO = 7;

  // Configuration register fields.
  localparam int unsigned CFG_LATCH_DIS = 15;
  localparam int unsigned CFG_POLARITY = 14;
  localparam int unsigned CFG_THR_SEL = 13;
  localparam int unsigned CFG_LOOP34_EN = 12;
  localparam int unsigned CFG_LOOP12_EN = 11;

  // Flag register fields: loop high alarms and the reserved bit.
  localparam int unsigned FLG_DAC4_HI = 15;
  localparam int unsigned FLG_DAC3_HI = 14;
  localparam int unsigned FLG_DAC2_HI = 13;
  localparam int unsigned FLG_DAC1_HI = 12;
  localparam int unsigned FLG_RSV = 11;
  localparam logic [15:0] FLG_USED = 16'hf7ff;

  // Interrupt status bits.
  localparam int unsigned IRQ_ALARM_RISE = 0;
  localparam int unsigned IRQ_AMP_OFF = 1;
  localparam int unsigned IRQ_CLAMP = 2;

  // Restore register field.
  localparam int unsigned AMP_RESTORE_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake states.
  typedef enum logic {
    AOC_BUS_IDLE,
    AOC_BUS_ANSWER
  } aoc_bus_e;

  // Whole state of the block.
  typedef struct packed {
    aoc_bus_e bus;
    logic [31:0] rdata;
    logic [15:0] clamp_cfg;
    logic [15:0] config_reg;
    logic [15:0] flags;
    logic [15:0] read_seen;
    logic alarm_act;
    logic pin_level;
    logic amp_off;
    logic [5:0] clamped;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic irq;
  } aoc_state_s;

  // Control outputs towards the analog side.
  typedef struct packed {
    logic amp_enable_pin;
    logic [5:0] dac_clamp;
    logic threshold_source_select;
  } aoc_ctrl_s;

endpackage

// ==== design/aoc_top.sv ====
// Purpose: Alarm output pin, amplifier shutdown and DAC clamp control with Avalon-MM registers.
// Assumes: alarm_cond is synchronous to sys_clk and uses the flag register layout.
// Notes: Every access takes one wait cycle; read data stand at the edge waitrequest is low.

////////////////////////////////////////////////////////////////////////////////
module aoc_top (
  // Clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Avalon-MM slave.
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Alarm conditions, one bit per source in flag layout.
  input wire logic [15:0] alarm_cond,
  // Pins and controls.
  output logic alarm_output_pin,
  output aoc_pkg::aoc_ctrl_s ctrl,
  output logic irq
);

  aoc_pkg::aoc_state_s s;
  aoc_pkg::aoc_state_s next_s;
  logic [7:0] idx;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  // Merge write data into a 16-bit register under the two low byte enables.
  function automatic logic [15:0] be_merge(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Write-one mask of the low 16 bits under byte enables.
  function automatic logic [15:0] be_ones(input logic [31:0] wd, input logic [3:0] be);
    return wd[15:0] & {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // Fold flags onto the thirteen enable positions and report any enabled one.
  function automatic logic alarm_any(input logic [15:0] f, input logic [15:0] cfg);
    logic [12:0] src;
    src = f[12:0];
    src[aoc_pkg::CFG_LOOP34_EN] = f[aoc_pkg::FLG_DAC4_HI] | f[aoc_pkg::FLG_DAC3_HI];
    src[aoc_pkg::CFG_LOOP12_EN] = f[aoc_pkg::FLG_DAC2_HI] | f[aoc_pkg::FLG_DAC1_HI];
    return |(src & cfg[12:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; the request is taken in the cycle the answer is given.
  assign idx = address[9:aoc_pkg::WORD_SHIFT];
  assign take = (read | write) & (s.bus == aoc_pkg::AOC_BUS_ANSWER);

  // One wait cycle lets read data come from a register.
  assign waitrequest = (read | write) & (s.bus != aoc_pkg::AOC_BUS_ANSWER);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic of the whole block.
  always_comb begin
    logic [15:0] ones;
    logic [15:0] rd_val;
    logic flags_read;
    logic amp_restore;
    logic [5:0] clamp_release;
    logic [2:0] irq_clear;
    logic set_amp;
    logic [5:0] set_clamp;
    logic [15:0] mask_new;
    ones = be_ones(writedata, byteenable);
    // The mask is merged as a full word first; a part-select of a call is not legal.
    mask_new = be_merge({13'h0000, s.irq_mask}, writedata, byteenable);
    set_amp = 1'b0;
    set_clamp = 6'h00;
    rd_val = 16'h0000;
    flags_read = 1'b0;
    amp_restore = 1'b0;
    clamp_release = 6'h00;
    irq_clear = 3'h0;
    next_s = s;

    // Bus handshake: the idle cycle fetches read data, the answer cycle completes.
    case (s.bus)
      aoc_pkg::AOC_BUS_IDLE: begin
        if (read | write) begin
          next_s.bus = aoc_pkg::AOC_BUS_ANSWER;
        end
      end
      aoc_pkg::AOC_BUS_ANSWER: begin
        next_s.bus = aoc_pkg::AOC_BUS_IDLE;
      end
      default: begin
        next_s.bus = aoc_pkg::AOC_BUS_IDLE;
      end
    endcase

    // Read data are sampled in the wait cycle and stand through the answer cycle.
    case (idx)
      aoc_pkg::IDX_CLAMP: rd_val = s.clamp_cfg;
      aoc_pkg::IDX_CONFIG: rd_val = s.config_reg;
      aoc_pkg::IDX_FLAGS: rd_val = s.flags;
      aoc_pkg::IDX_IRQ_STATUS: rd_val = {13'h0000, s.irq_status};
      aoc_pkg::IDX_IRQ_MASK: rd_val = {13'h0000, s.irq_mask};
      aoc_pkg::IDX_AMP_RESTORE: rd_val = {15'h0000, s.amp_off};
      aoc_pkg::IDX_CLAMP_RELEASE: rd_val = {10'h000, s.clamped};
      default: rd_val = 16'h0000;
    endcase
    if ((s.bus == aoc_pkg::AOC_BUS_IDLE) & read) begin
      next_s.rdata = {16'h0000, rd_val};
    end

    // Register writes and read side effects happen only at the answer edge.
    if (take & write) begin
      case (idx)
        aoc_pkg::IDX_CLAMP: begin
          next_s.clamp_cfg = be_merge(s.clamp_cfg, writedata, byteenable);
        end
        aoc_pkg::IDX_CONFIG: begin
          next_s.config_reg = be_merge(s.config_reg, writedata, byteenable);
        end
        aoc_pkg::IDX_IRQ_STATUS: irq_clear = ones[2:0];
        aoc_pkg::IDX_IRQ_MASK: begin
          next_s.irq_mask = mask_new[2:0];
        end
        aoc_pkg::IDX_AMP_RESTORE: amp_restore = ones[aoc_pkg::AMP_RESTORE_BIT];
        aoc_pkg::IDX_CLAMP_RELEASE: clamp_release = ones[5:0];
        default: begin
        end
      endcase
    end
    flags_read = take & read & (idx == aoc_pkg::IDX_FLAGS);

    // Flags: on every used bit a present condition wins over any clear.
    for (int i = 0; i < aoc_pkg::REG_W; i++) begin
      if (!aoc_pkg::FLG_USED[i]) begin
        next_s.flags[i] = 1'b0;
        next_s.read_seen[i] = 1'b0;
      end else if (alarm_cond[i]) begin
        next_s.flags[i] = 1'b1;
        next_s.read_seen[i] = (s.flags[i] & (s.read_seen[i] | flags_read));
      end else if (s.config_reg[aoc_pkg::CFG_LATCH_DIS]) begin
        next_s.flags[i] = 1'b0;
        next_s.read_seen[i] = 1'b0;
      end else begin
        // A read marks the flag; it drops once the condition has gone too.
        next_s.flags[i] = s.flags[i] & ~(s.read_seen[i] | flags_read);
        next_s.read_seen[i] = 1'b0;
      end
    end

    // Alarm state and pin level follow the new flags without an extra cycle.
    next_s.alarm_act = alarm_any(next_s.flags, next_s.config_reg);
    next_s.pin_level = next_s.config_reg[aoc_pkg::CFG_POLARITY] ?
                       next_s.alarm_act : ~next_s.alarm_act;

    // Shutdown and clamps are sticky; setting wins over a release in the same cycle.
    set_amp = s.alarm_act & s.clamp_cfg[aoc_pkg::CLP_AMP_OFF];
    set_clamp = {6{s.alarm_act}} & s.clamp_cfg[5:0];
    next_s.amp_off = set_amp | (s.amp_off & ~amp_restore);
    next_s.clamped = set_clamp | (s.clamped & ~clamp_release);

    // Interrupt events: alarm rising, a new shutdown, a new clamp.
    next_s.irq_status[aoc_pkg::IRQ_ALARM_RISE] = (next_s.alarm_act & ~s.alarm_act) |
      (s.irq_status[aoc_pkg::IRQ_ALARM_RISE] & ~irq_clear[aoc_pkg::IRQ_ALARM_RISE]);
    next_s.irq_status[aoc_pkg::IRQ_AMP_OFF] = (set_amp & ~s.amp_off) |
      (s.irq_status[aoc_pkg::IRQ_AMP_OFF] & ~irq_clear[aoc_pkg::IRQ_AMP_OFF]);
    next_s.irq_status[aoc_pkg::IRQ_CLAMP] = (|(set_clamp & ~s.clamped)) |
      (s.irq_status[aoc_pkg::IRQ_CLAMP] & ~irq_clear[aoc_pkg::IRQ_CLAMP]);
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves all sources masked, flags latched, pin active low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.bus <= aoc_pkg::AOC_BUS_IDLE;
      s.clamp_cfg <= aoc_pkg::CLAMP_RESET;
      s.config_reg <= aoc_pkg::CONFIG_RESET;
      s.pin_level <= 1'b1;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register.
  assign readdata = s.rdata;
  assign alarm_output_pin = s.pin_level;
  assign irq = s.irq;
  assign ctrl.amp_enable_pin = ~s.amp_off;
  assign ctrl.dac_clamp = s.clamped;
  // The threshold comparators live elsewhere; this only steers their source.
  assign ctrl.threshold_source_select = s.config_reg[aoc_pkg::CFG_THR_SEL];

endmodule // aoc_top

// ==== test/aoc_cond_model.sv ====
// Purpose: Alarm condition source standing for the analog monitors.
// Assumes: Conditions change only on the clock.
// Notes: One register stage, as the sensor compare logic would add.
module aoc_cond_model (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Requested and driven conditions.
  input wire logic [15:0] want,
  output logic [15:0] alarm_cond
);
  // Conditions drop at reset so no stale event survives it.
  always_ff @(posedge sys_clk) alarm_cond <= rst ? 16'h0000 : want;
endmodule // aoc_cond_model

// ==== test/aoc_top_checker.sv ====
// Purpose: Bus, reset and persistence checks on the ports of the alarm block.
// Assumes: Clock enable is held high.
// Notes: Bound to every instance of the top module.
module aoc_top_checker (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus.
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Pins and controls.
  input wire logic alarm_output_pin,
  input wire aoc_pkg::aoc_ctrl_s ctrl,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A request still waiting, and one completing at this edge.
  sequence wait_s; (read || write) && waitrequest; endsequence
  sequence done_s; (read || write) && !waitrequest; endsequence
  wait_one_a: assert property (wait_s |=> done_s)
    else $error("access not answered after one wait cycle");
  release_a: assert property (done_s |=> !(read || write) || waitrequest)
    else $error("access answered without a wait cycle");
  rd_upper_a: assert property (done_s ##0 read |-> readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  rdata_hold_a: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data changed outside a read");
  reset_vals_a: assert property ($past(rst) |-> alarm_output_pin && ctrl.amp_enable_pin
    && ctrl.dac_clamp == 6'h00 && !irq) else $error("outputs wrong after reset");
  clamp_hold_a: assert property (|($past(ctrl.dac_clamp) & ~ctrl.dac_clamp) && !$past(rst)
    |-> $past(write && !waitrequest && address[9:2] == aoc_pkg::IDX_CLAMP_RELEASE))
    else $error("clamp released without a release write");
  amp_hold_a: assert property ($rose(ctrl.amp_enable_pin) && !$past(rst)
    |-> $past(write && !waitrequest && address[9:2] == aoc_pkg::IDX_AMP_RESTORE))
    else $error("amplifier enabled again without a restore write");
  thr_sel_a: assert property (done_s ##0 (write && address[9:2] == aoc_pkg::IDX_CONFIG
    && byteenable[1]) |=> ctrl.threshold_source_select == $past(writedata[13]))
    else $error("threshold select does not follow config bit");
endmodule // aoc_top_checker

bind aoc_top aoc_top_checker aoc_top_checker_i (.sys_clk(sys_clk), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .alarm_output_pin(alarm_output_pin), .ctrl(ctrl), .irq(irq));

// ==== test/aoc_top_tb.sv ====
// Purpose: Self-checking bench of the alarm output and clamp block.
// Assumes: Clock enable held high except in the four-cycle clock enable test; 25 MHz clock.
// Notes: Polarity, select and clamp values are random from a fixed seed.
module aoc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, p, waitrequest, pin, irq;
  logic en = 1'b1;
  logic [9:0] address = 10'h000;
  logic [31:0] writedata = 32'h0, q, readdata;
  logic [3:0] byteenable = 4'h0;
  logic [15:0] want = 16'h0000, c, alarm_cond;
  logic [7:0] idx[3] = '{aoc_pkg::IDX_CLAMP, aoc_pkg::IDX_CONFIG, 8'h30};
  aoc_pkg::aoc_ctrl_s ctrl;
  int bad_count = 0, n_checks = 0, cyc = 0;
  aoc_top aoc_top_i (.sys_clk(sys_clk), .rst(rst), .clk_en(en), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .alarm_cond(alarm_cond),
    .alarm_output_pin(pin), .ctrl(ctrl), .irq(irq));
  aoc_cond_model aoc_cond_model_i (.sys_clk(sys_clk), .rst(rst), .want(want),
    .alarm_cond(alarm_cond));
  always #20 sys_clk = ~sys_clk;
  // The tests take about 350 cycles, so a hang is cut well beyond.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One access held until waitrequest is low; an idle edge follows it.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int n;
    logic w;
    n = 0;
    address <= {a, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {16'h0000, d};
    byteenable <= 4'h3;
    // Sample the answer mid-cycle so the edge that completes the access is the one seen.
    do begin
      @(negedge sys_clk);
      w = waitrequest;
      q = readdata;
      @(posedge sys_clk);
      n++;
    end while (w !== 1'b0 && n < 50);
    read <= 1'b0;
    write <= 1'b0;
    if (n == 50) bad_count++;
    @(posedge sys_clk);
  endtask
  // Flag bit that feeds enable k; the loop enables use their high flags.
  function automatic int fbit(input int k);
    return k == 12 ? 15 : k == 11 ? 12 : k;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(68187));
    tick(8);
    rst <= 1'b0;
    tick(1);
    foreach (idx[i]) begin
      bus(0, idx[i], 16'h0000);
      chk(q, 0);
    end
    chk({ctrl, pin}, 9'h101);
    // Each enable passes only its own event, latched until the flags are read.
    for (int k = 0; k < 13; k++) begin
      p = 1'($urandom);
      c = 16'h0000;
      c[14] = p;
      c[k] = 1'b1;
      bus(1, aoc_pkg::IDX_CONFIG, c);
      want <= (k == 0) ? 16'h0002 : 16'h0001;
      tick(4);
      chk(pin, !p);
      want <= 16'h0001 << fbit(k);
      tick(4);
      chk(pin, p);
      want <= 16'h0000;
      tick(4);
      chk(pin, p);
      bus(0, aoc_pkg::IDX_FLAGS, 16'h0000);
      chk(q[fbit(k)], 1);
      tick(3);
      chk(pin, !p);
    end
    // Unlatched flags follow the condition.
    p = 1'($urandom);
    bus(1, aoc_pkg::IDX_CONFIG, {2'b10, p, 13'h0001});
    chk(ctrl.threshold_source_select, p);
    // With the clock enable low the pin must not follow a new condition.
    en <= 1'b0;
    want <= 16'h0001;
    tick(4);
    chk(pin, 1);
    en <= 1'b1;
    tick(4);
    chk(pin, 0);
    want <= 16'h0000;
    tick(4);
    chk(pin, 1);
    // Shutdown, clamps and interrupt, then release by software.
    c = 16'($urandom) | 16'h0041;
    bus(1, aoc_pkg::IDX_CLAMP, c);
    bus(0, aoc_pkg::IDX_CLAMP, 16'h0000);
    chk(q, c);
    bus(1, aoc_pkg::IDX_CONFIG, 16'h4001);
    want <= 16'h0001;
    tick(4);
    chk({ctrl.amp_enable_pin, ctrl.dac_clamp, irq}, {1'b0, c[5:0], 1'b0});
    bus(0, aoc_pkg::IDX_IRQ_STATUS, 16'h0000);
    chk(q, 7);
    bus(1, aoc_pkg::IDX_IRQ_MASK, 16'h0007);
    tick(2);
    chk(irq, 1);
    want <= 16'h0000;
    bus(0, aoc_pkg::IDX_FLAGS, 16'h0000);
    bus(1, aoc_pkg::IDX_IRQ_STATUS, 16'h0007);
    tick(2);
    chk({pin, ctrl.amp_enable_pin, ctrl.dac_clamp, irq}, {2'b00, c[5:0], 1'b0});
    bus(1, aoc_pkg::IDX_AMP_RESTORE, 16'h0001);
    bus(1, aoc_pkg::IDX_CLAMP_RELEASE, 16'h003f);
    tick(1);
    chk({ctrl.amp_enable_pin, ctrl.dac_clamp}, 7'h40);
    bus(1, aoc_pkg::IDX_CLAMP, 16'h0000);
    want <= 16'h0001;
    tick(4);
    chk({pin, ctrl.amp_enable_pin, ctrl.dac_clamp}, 8'hc0);
    results();
  end
endmodule // aoc_top_tb
